//--- hw/scpi_event_group.sv
`timescale 1ns/1ps
`include "status_event_reporting_consts.svh"
// one condition/transition/event/enable group with a summary output
module scpi_event_group (
   input wire logic CLK,
   input wire logic RST,
   input wire status_event_reporting_pkg::word_t COND,
   input wire status_event_reporting_pkg::word_t PTR_IN,
   input wire logic PTR_WE,
   input wire status_event_reporting_pkg::word_t NTR_IN,
   input wire logic NTR_WE,
   input wire status_event_reporting_pkg::word_t ENAB_IN,
   input wire logic ENAB_WE,
   input wire logic EVENT_CLR,
   output logic [15:0] EVENT,
   output logic SUMMARY
);
   import status_event_reporting_pkg::*;
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      word_t cond_q; // previous condition sample
      word_t ptr;    // positive transition filter
      word_t ntr;    // negative transition filter
      word_t enab;   // summary enable
      word_t evt;    // latched events
      logic sum;     // summary bit
   } grp_s;
   grp_s st_ff;
   grp_s nxt_st;
   word_t hits;
   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.cond_q = COND;
      // rising edges through ptr, falling through ntr; both gives every change
      hits = (COND & ~st_ff.cond_q & st_ff.ptr) | (~COND & st_ff.cond_q & st_ff.ntr); // R16 R17 R21
      if (PTR_WE) begin
         nxt_st.ptr = PTR_IN;
      end
      if (NTR_WE) begin
         nxt_st.ntr = NTR_IN;
      end
      if (ENAB_WE) begin
         nxt_st.enab = ENAB_IN;
      end
      // held until read/clear; a new hit in the clear cycle still wins
      nxt_st.evt = (EVENT_CLR ? 16'h0000 : st_ff.evt) | hits; // R18 R23
      nxt_st.sum = |(nxt_st.evt & nxt_st.enab); // R19 R24
   end
   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_ff <= '0; // R26
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign EVENT = st_ff.evt;
   assign SUMMARY = st_ff.sum;

   a_grp_rise: assert property (@(posedge CLK) disable iff (RST) // R16
      (!$past(RST) && COND[0] && !st_ff.cond_q[0] && st_ff.ptr[0]) |=> st_ff.evt[0])
      else $error("rising enabled condition did not set event");
   a_grp_hold: assert property (@(posedge CLK) disable iff (RST) // R23
      (st_ff.evt[1] && !EVENT_CLR) |=> st_ff.evt[1])
      else $error("event bit dropped without clear");
endmodule

//--- hw/status_event_reporting.sv
`timescale 1ns/1ps
`include "status_event_reporting_consts.svh"
// Overview of operation
// (R1) power-on event bit set after power-up
// (R2) nonzero modbus error sets event bit 6
// (R3) bad command or range sets bit 5
// (R4) unexecutable valid command sets bit 4
// (R5) corrupt config sets bit 3 until date write
// (R6) unread or missing response sets bit 2
// (R7) bits 1 and 0 always zero
// (R8) event query returns then clears; clear-status clears
// (R9) enable mask written by client, read back
// (R10) modbus error register holds latest code
// (R11) error query clears register and bit 6
// (R12) clear-status and reset leave error register
// (R13) client enables 64 and 32 for modbus requests
// (R14) questionable holds crc, exception, timeout conditions
// (R15) crc in bit 12, timeout in bit 13
// (R16) positive filter catches rising condition
// (R17) both filters catch every change
// (R18) questionable events cleared by read or clear-status
// (R19) only enabled questionable events form summary
// (R20) client clears questionable events after each request
// (R21) operation group filters alarms and local/remote
// (R22) status bit 4 while output queue unread
// (R23) event bits held until read or cleared
// (R24) summary is OR of events and enables
// (R25) service request on enabled status bit
// (R26) reset zeros everything except power-on bit
module status_event_reporting (
   input wire logic CLK,
   input wire logic RST,
   input wire status_event_reporting_pkg::status_cmd_e CMD,
   input wire status_event_reporting_pkg::word_t CMD_DATA,
   input wire logic CMD_ERR_EVT,
   input wire logic EXEC_ERR_EVT,
   input wire logic CONFIG_BAD_EVT,
   input wire logic CONFIG_DATE_WRITE,
   input wire logic QUERY_ERR_EVT,
   input wire logic MBERR_LOAD,
   input wire status_event_reporting_pkg::word_t MBERR_CODE,
   input wire logic CRC_ERR_PIN,
   input wire logic TIMEOUT_PIN,
   input wire status_event_reporting_pkg::byte_t EXC_TYPE_PIN,
   input wire logic [3:0] ALARM_PIN,
   input wire logic REMOTE_PIN,
   input wire logic QUEUE_HAS_DATA,
   output logic [15:0] READ_DATA,
   output logic READ_VALID,
   output logic [7:0] STATUS_BYTE,
   output logic SERVICE_REQ,
   output logic [7:0] ESE_MASK
);
   import status_event_reporting_pkg::*;
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      logic [1:0] pin_a;      // first synchroniser stage, crc/timeout
      logic [1:0] pin_b;      // second stage
      byte_t exc_a;           // exception type, first stage
      byte_t exc_b;           // second stage
      logic [4:0] op_a;       // alarms + remote, first stage
      logic [4:0] op_b;       // second stage
      byte_t seb;             // standard event bits
      logic cfg_hold;         // config corruption persists until date write
      byte_t ese;             // standard event enable
      byte_t sre;             // service request enable
      word_t mberr;           // last modbus error code
      word_t rdata;           // query response
      logic rvalid;           // response strobe
      byte_t stb;             // status byte
      logic srq;              // service request level
   } top_s;
   top_s st_ff;
   top_s nxt_st;
   // ---------------------------------------------
   // group control decode
   // ---------------------------------------------
   word_t ques_cond;
   word_t oper_cond;
   word_t ques_evt;
   word_t oper_evt;
   logic ques_sum;
   logic oper_sum;
   logic cls;
   logic ques_clr;
   logic oper_clr;

   // question: is command c this cycle
   function automatic logic is_cmd(input status_cmd_e cur, input status_cmd_e c);
      return cur == c;
   endfunction

   assign cls = is_cmd(CMD, CMD_CLS);
   assign ques_clr = cls | is_cmd(CMD, CMD_QUES_EVENT_QUERY); // R18
   assign oper_clr = cls | is_cmd(CMD, CMD_OPER_EVENT_QUERY);

   // condition words built from synchronised pins only
   always_comb begin
      ques_cond = 16'h0000;
      ques_cond[`QB_CRC_ERR] = st_ff.pin_b[0]; // R14 R15
      ques_cond[`QB_TIMEOUT] = st_ff.pin_b[1]; // R15
      ques_cond[`QB_EXC_LSB +: `QB_EXC_WIDTH] = st_ff.exc_b; // R14
      oper_cond = {11'h000, st_ff.op_b}; // R21: alarms bits 0..3, remote bit 4
   end

   // ---------------------------------------------
   // questionable and operation groups
   // ---------------------------------------------
   scpi_event_group u_ques (
      .CLK(CLK),
      .RST(RST),
      .COND(ques_cond),
      .PTR_IN(CMD_DATA),
      .PTR_WE(is_cmd(CMD, CMD_QUES_PTR_WRITE)),
      .NTR_IN(CMD_DATA),
      .NTR_WE(is_cmd(CMD, CMD_QUES_NTR_WRITE)),
      .ENAB_IN(CMD_DATA),
      .ENAB_WE(is_cmd(CMD, CMD_QUES_ENAB_WRITE)),
      .EVENT_CLR(ques_clr),
      .EVENT(ques_evt),
      .SUMMARY(ques_sum)
   );
   scpi_event_group u_oper (
      .CLK(CLK),
      .RST(RST),
      .COND(oper_cond),
      .PTR_IN(CMD_DATA),
      .PTR_WE(is_cmd(CMD, CMD_OPER_PTR_WRITE)),
      .NTR_IN(CMD_DATA),
      .NTR_WE(is_cmd(CMD, CMD_OPER_NTR_WRITE)),
      .ENAB_IN(CMD_DATA),
      .ENAB_WE(is_cmd(CMD, CMD_OPER_ENAB_WRITE)),
      .EVENT_CLR(oper_clr),
      .EVENT(oper_evt),
      .SUMMARY(oper_sum)
   );

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      byte_t sets; // events raised this cycle
      logic esb;
      nxt_st = st_ff;
      sets = 8'h00;
      esb = 1'b0;
      // two-flop synchronisers for pin inputs
      nxt_st.pin_a = {TIMEOUT_PIN, CRC_ERR_PIN};
      nxt_st.pin_b = st_ff.pin_a;
      nxt_st.exc_a = EXC_TYPE_PIN;
      nxt_st.exc_b = st_ff.exc_a;
      nxt_st.op_a = {REMOTE_PIN, ALARM_PIN};
      nxt_st.op_b = st_ff.op_a;
      nxt_st.rvalid = 1'b0;
      // modbus error register; untouched by clear-status and reset commands
      if (is_cmd(CMD, CMD_MBERR_QUERY)) begin
         nxt_st.mberr = 16'h0000; // R11
      end
      if (MBERR_LOAD) begin
         nxt_st.mberr = MBERR_CODE; // R10 R12
      end
      // config corruption flag survives everything but the date write and RST
      if (CONFIG_DATE_WRITE) begin
         nxt_st.cfg_hold = 1'b0; // R5
      end
      if (CONFIG_BAD_EVT) begin
         nxt_st.cfg_hold = 1'b1; // R5
      end
      // event sources
      sets[`SEB_MODBUS_ERR] = MBERR_LOAD && (MBERR_CODE != 16'h0000); // R2
      sets[`SEB_CMD_ERR] = CMD_ERR_EVT; // R3
      sets[`SEB_EXEC_ERR] = EXEC_ERR_EVT; // R4
      sets[`SEB_CONFIG_BAD] = nxt_st.cfg_hold; // R5
      sets[`SEB_QUERY_ERR] = QUERY_ERR_EVT; // R6
      // clears first, so a same-cycle set wins
      if (cls || is_cmd(CMD, CMD_ESR_QUERY)) begin
         nxt_st.seb = 8'h00; // R8
      end
      if (is_cmd(CMD, CMD_MBERR_QUERY)) begin
         nxt_st.seb[`SEB_MODBUS_ERR] = 1'b0; // R11
      end
      // only the date write retires the corruption bit; a new corruption still wins
      if (CONFIG_DATE_WRITE) begin
         nxt_st.seb[`SEB_CONFIG_BAD] = 1'b0; // R5
      end
      nxt_st.seb = (nxt_st.seb | sets) & `SEB_WRITABLE_MASK; // R7 R23
      // command handling
      case (CMD)
         CMD_ESE_WRITE: begin
            nxt_st.ese = CMD_DATA[7:0]; // R9
         end
         CMD_SRE_WRITE: begin
            nxt_st.sre = CMD_DATA[7:0];
         end
         CMD_ESR_QUERY: begin
            // value returned before the clear takes effect
            nxt_st.rdata = {8'h00, st_ff.seb}; // R8
            nxt_st.rvalid = 1'b1;
         end
         CMD_ESE_QUERY: begin
            nxt_st.rdata = {8'h00, st_ff.ese}; // R9
            nxt_st.rvalid = 1'b1;
         end
         CMD_MBERR_QUERY: begin
            nxt_st.rdata = st_ff.mberr; // R11
            nxt_st.rvalid = 1'b1;
         end
         CMD_QUES_EVENT_QUERY: begin
            nxt_st.rdata = ques_evt; // R18
            nxt_st.rvalid = 1'b1;
         end
         CMD_OPER_EVENT_QUERY: begin
            nxt_st.rdata = oper_evt;
            nxt_st.rvalid = 1'b1;
         end
         default: begin
            // writes to groups and clears handled elsewhere
         end
      endcase
      // status byte built from summaries and the queue flag
      esb = |(st_ff.seb & st_ff.ese); // R24
      nxt_st.stb = 8'h00;
      nxt_st.stb[`SB_QUES_SUM] = ques_sum; // R19
      nxt_st.stb[`SB_MAV] = QUEUE_HAS_DATA; // R22
      nxt_st.stb[`SB_ESB] = esb;
      nxt_st.stb[`SB_OPER_SUM] = oper_sum;
      // service request level; follows the enabled status byte bits one cycle later, not latched
      nxt_st.srq = |(st_ff.stb & st_ff.sre); // R25
   end

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_ff <= '0; // R26
         st_ff.seb <= `SEB_RESET; // R1
         st_ff.mberr <= `MBERR_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign READ_DATA = st_ff.rdata;
   assign READ_VALID = st_ff.rvalid;
   assign STATUS_BYTE = st_ff.stb;
   assign SERVICE_REQ = st_ff.srq;
   assign ESE_MASK = st_ff.ese;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   a_power_on_bit: assert property (@(posedge CLK) $fell(RST) |-> st_ff.seb[7]) // R1
      else $error("power-on bit not set after reset");
   a_mberr_sets_bit: assert property (@(posedge CLK) disable iff (RST) // R2
      (MBERR_LOAD && MBERR_CODE != 16'h0000) |=> st_ff.seb[6])
      else $error("modbus error did not set bit 6");
   a_cmd_err_bit: assert property (@(posedge CLK) disable iff (RST) // R3
      CMD_ERR_EVT |=> st_ff.seb[5])
      else $error("command error not recorded");
   a_exec_err_bit: assert property (@(posedge CLK) disable iff (RST) // R4
      EXEC_ERR_EVT |=> st_ff.seb[4])
      else $error("execution error not recorded");
   a_low_bits_zero: assert property (@(posedge CLK) disable iff (RST) // R7
      st_ff.seb[1:0] == 2'b00)
      else $error("unused event bits set");
   a_esr_read_clear: assert property (@(posedge CLK) disable iff (RST) // R8
      (CMD == CMD_ESR_QUERY && !CMD_ERR_EVT && !EXEC_ERR_EVT && !QUERY_ERR_EVT
       && !MBERR_LOAD && !st_ff.cfg_hold && !CONFIG_BAD_EVT)
      |=> (READ_VALID && READ_DATA[7:0] == $past(st_ff.seb) && st_ff.seb == 8'h00))
      else $error("event query did not return and clear");
   a_mberr_keep: assert property (@(posedge CLK) disable iff (RST) // R12
      ((CMD == CMD_CLS || CMD == CMD_RST) && !MBERR_LOAD) |=> $stable(st_ff.mberr))
      else $error("modbus error register changed on clear");
   a_mav_follow: assert property (@(posedge CLK) disable iff (RST) // R22
      QUEUE_HAS_DATA |=> STATUS_BYTE[4])
      else $error("queue bit not shown");
   a_srq_follow: assert property (@(posedge CLK) disable iff (RST) // R25
      |(STATUS_BYTE & st_ff.sre) |=> SERVICE_REQ)
      else $error("service request missing");
   // query error pulse lands in bit 2
   a_query_err_bit: assert property (@(posedge CLK) disable iff (RST) // R6
      QUERY_ERR_EVT |=> st_ff.seb[2])
      else $error("query error not recorded");
   // corruption bit comes back after every event query while held
   a_cfg_bad_hold: assert property (@(posedge CLK) disable iff (RST) // R5
      (st_ff.cfg_hold && !CONFIG_DATE_WRITE) |=> st_ff.seb[3])
      else $error("config corruption bit lost");
   // date write alone retires it
   a_cfg_date_clear: assert property (@(posedge CLK) disable iff (RST) // R5
      (CONFIG_DATE_WRITE && !CONFIG_BAD_EVT) |=> !st_ff.seb[3])
      else $error("config corruption bit not cleared");
   // error query answers the old code, then empties register and bit 6
   a_mberr_query_clr: assert property (@(posedge CLK) disable iff (RST) // R11
      (CMD == CMD_MBERR_QUERY && !MBERR_LOAD)
      |=> (READ_DATA == $past(st_ff.mberr) && st_ff.mberr == 16'h0000 && !st_ff.seb[6]))
      else $error("modbus error query did not return and clear");
   // mask write lands in the low byte only
   a_ese_write: assert property (@(posedge CLK) disable iff (RST) // R9
      CMD == CMD_ESE_WRITE |=> {8'h00, ESE_MASK} == ($past(CMD_DATA) & 16'h00ff))
      else $error("enable mask not stored");
   // enabled standard events reach the status byte one edge later
   a_esb_follow: assert property (@(posedge CLK) disable iff (RST) // R24
      |(st_ff.seb & st_ff.ese) |=> STATUS_BYTE[5])
      else $error("event summary bit missing");
   // questionable summary forwarded
   a_ques_sum_follow: assert property (@(posedge CLK) disable iff (RST) // R19
      ques_sum |=> STATUS_BYTE[3])
      else $error("questionable summary bit missing");
   // operation summary forwarded
   a_oper_sum_follow: assert property (@(posedge CLK) disable iff (RST) // R24
      oper_sum |=> STATUS_BYTE[7])
      else $error("operation summary bit missing");
endmodule

//--- hw/status_event_reporting_consts.svh
`ifndef STATUS_EVENT_REPORTING_CONSTS_SVH
`define STATUS_EVENT_REPORTING_CONSTS_SVH
// ---------------------------------------------
// standard event bit positions
// ---------------------------------------------
`define SEB_POWER_ON 7
`define SEB_MODBUS_ERR 6
`define SEB_CMD_ERR 5
`define SEB_EXEC_ERR 4
`define SEB_CONFIG_BAD 3
`define SEB_QUERY_ERR 2
// only bits 2..7 may ever be set; bits 1 and 0 stay zero
`define SEB_WRITABLE_MASK 8'hfc
// ---------------------------------------------
// questionable condition positions
// ---------------------------------------------
`define QB_CRC_ERR 12
`define QB_TIMEOUT 13
// exception response type field, low bits of the questionable register
`define QB_EXC_LSB 0
`define QB_EXC_WIDTH 8
// ---------------------------------------------
// status byte positions
// ---------------------------------------------
`define SB_QUES_SUM 3
`define SB_MAV 4
`define SB_ESB 5
`define SB_OPER_SUM 7
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define SEB_RESET 8'h80
`define MBERR_RESET 16'h0000
`endif

//--- hw/status_event_reporting_pkg.sv
package status_event_reporting_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
   // status command codes
   typedef enum logic [3:0] {
      CMD_NONE,
      CMD_CLS,
      CMD_RST,
      CMD_ESR_QUERY,
      CMD_ESE_WRITE,
      CMD_ESE_QUERY,
      CMD_MBERR_QUERY,
      CMD_QUES_EVENT_QUERY,
      CMD_QUES_PTR_WRITE,
      CMD_QUES_NTR_WRITE,
      CMD_QUES_ENAB_WRITE,
      CMD_OPER_EVENT_QUERY,
      CMD_OPER_PTR_WRITE,
      CMD_OPER_NTR_WRITE,
      CMD_OPER_ENAB_WRITE,
      CMD_SRE_WRITE
   } status_cmd_e;
endpackage

//--- verification/status_client.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote client issuing status commands
// ----------------------------------------
module status_client (
   input wire logic CLK,
   output status_event_reporting_pkg::status_cmd_e CMD,
   output status_event_reporting_pkg::word_t CMD_DATA,
   input wire logic [15:0] READ_DATA,
   input wire logic READ_VALID
);
   import status_event_reporting_pkg::*;
   // idle bus at time zero
   initial begin
      CMD = CMD_NONE;
      CMD_DATA = 16'h0000;
   end
   // one command, one cycle; data inverted when idle so stale data is never seen
   task automatic issue(input status_cmd_e c, input word_t d);
      @(negedge CLK);
      CMD = c;
      CMD_DATA = d;
      @(negedge CLK);
      CMD = CMD_NONE;
      CMD_DATA = ~d;
   endtask
   // query and take the answer on its valid pulse, bounded wait
   task automatic query(input status_cmd_e c, output word_t d, output logic ok);
      issue(c, 16'h0000);
      ok = 1'b0;
      d = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (READ_VALID === 1'b1) begin
            ok = 1'b1;
            d = READ_DATA;
         end else begin
            @(negedge CLK);
         end
      end
   endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import status_event_reporting_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic CLK, RST;
   status_cmd_e CMD;
   word_t CMD_DATA, MBERR_CODE;
   logic cmd_err, exec_err, cfg_bad, cfg_date, qry_err, mb_load;
   logic crc, tmo, remote, queue;
   byte_t exc;
   logic [3:0] alarm;
   logic [15:0] READ_DATA;
   logic READ_VALID, SERVICE_REQ;
   logic [7:0] STATUS_BYTE, ESE_MASK;
   int n_fail = 0;
   int checks = 0;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   status_event_reporting status_event_reporting_inst (.CLK(CLK), .RST(RST), .CMD(CMD),
      .CMD_DATA(CMD_DATA), .CMD_ERR_EVT(cmd_err), .EXEC_ERR_EVT(exec_err),
      .CONFIG_BAD_EVT(cfg_bad), .CONFIG_DATE_WRITE(cfg_date), .QUERY_ERR_EVT(qry_err),
      .MBERR_LOAD(mb_load), .MBERR_CODE(MBERR_CODE), .CRC_ERR_PIN(crc), .TIMEOUT_PIN(tmo),
      .EXC_TYPE_PIN(exc), .ALARM_PIN(alarm), .REMOTE_PIN(remote), .QUEUE_HAS_DATA(queue),
      .READ_DATA(READ_DATA), .READ_VALID(READ_VALID), .STATUS_BYTE(STATUS_BYTE),
      .SERVICE_REQ(SERVICE_REQ), .ESE_MASK(ESE_MASK));
   status_client status_client_inst (.CLK(CLK), .CMD(CMD), .CMD_DATA(CMD_DATA),
      .READ_DATA(READ_DATA), .READ_VALID(READ_VALID));
   // 200 MHz clock
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   // query with a bounded wait; a missing answer ends the run
   task automatic q(input status_cmd_e c, input logic [15:0] exp);
      word_t d;
      logic ok;
      status_client_inst.query(c, d, ok);
      if (!ok) begin
         n_fail++;
         stop_test();
      end else begin
         chk_word(d, exp);
      end
   endtask
   task automatic cmd(input status_cmd_e c, input word_t d);
      status_client_inst.issue(c, d);
   endtask
   // one-cycle event pulse on input k
   task automatic pulse(input int k);
      @(negedge CLK);
      case (k)
         0: cmd_err = 1'b1;
         1: exec_err = 1'b1;
         2: qry_err = 1'b1;
         3: cfg_bad = 1'b1;
         4: cfg_date = 1'b1;
         default: mb_load = 1'b1;
      endcase
      @(negedge CLK);
      {cmd_err, exec_err, qry_err, cfg_bad, cfg_date, mb_load} = 6'h00;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge CLK);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      q(CMD_ESR_QUERY, 16'h0080);
      q(CMD_ESR_QUERY, 16'h0000);
      q(CMD_MBERR_QUERY, 16'h0000);
      chk_word({8'h00, ESE_MASK}, 16'h0000);
   endtask
   task automatic t_std_events();
      logic [15:0] w[3] = '{16'h0020, 16'h0010, 16'h0004};
      for (int k = 0; k < 3; k++) begin
         pulse(k);
         q(CMD_ESR_QUERY, w[k]);
      end
      pulse(3);
      q(CMD_ESR_QUERY, 16'h0008);
      q(CMD_ESR_QUERY, 16'h0008);
      pulse(4);
      q(CMD_ESR_QUERY, 16'h0000);
      pulse(0);
      cmd(CMD_CLS, 16'h0000);
      q(CMD_ESR_QUERY, 16'h0000);
   endtask
   task automatic t_modbus();
      MBERR_CODE = 16'h0000;
      pulse(5);
      q(CMD_ESR_QUERY, 16'h0000);
      cmd(CMD_ESE_WRITE, 16'h003c);
      chk_word({8'h00, ESE_MASK}, 16'h003c);
      cmd(CMD_ESE_WRITE, 16'h007c);
      q(CMD_ESE_QUERY, 16'h007c);
      MBERR_CODE = 16'h0005;
      pulse(5);
      cmd(CMD_ESE_WRITE, 16'h0040);
      cmd(CMD_SRE_WRITE, 16'h0020);
      idle(4);
      chk_bit(STATUS_BYTE[5], 1'b1);
      chk_bit(SERVICE_REQ, 1'b1);
      cmd(CMD_CLS, 16'h0000);
      cmd(CMD_RST, 16'h0000);
      idle(4);
      chk_bit(STATUS_BYTE[5], 1'b0);
      q(CMD_MBERR_QUERY, 16'h0005);
      MBERR_CODE = 16'h0007;
      pulse(5);
      q(CMD_MBERR_QUERY, 16'h0007);
      q(CMD_ESR_QUERY, 16'h0000);
      q(CMD_MBERR_QUERY, 16'h0000);
   endtask
   task automatic t_ques();
      cmd(CMD_QUES_PTR_WRITE, 16'h3000);
      cmd(CMD_QUES_NTR_WRITE, 16'h2000);
      cmd(CMD_QUES_ENAB_WRITE, 16'h1000);
      cmd(CMD_SRE_WRITE, 16'h0008);
      crc = 1'b1;
      idle(6);
      chk_bit(STATUS_BYTE[3], 1'b1);
      chk_bit(SERVICE_REQ, 1'b1);
      crc = 1'b0;
      idle(6);
      q(CMD_QUES_EVENT_QUERY, 16'h1000);
      tmo = 1'b1;
      idle(6);
      chk_bit(STATUS_BYTE[3], 1'b0);
      chk_bit(SERVICE_REQ, 1'b0);
      q(CMD_QUES_EVENT_QUERY, 16'h2000);
      tmo = 1'b0;
      idle(6);
      q(CMD_QUES_EVENT_QUERY, 16'h2000);
      crc = 1'b1;
      idle(6);
      cmd(CMD_CLS, 16'h0000);
      q(CMD_QUES_EVENT_QUERY, 16'h0000);
      crc = 1'b0;
   endtask
   task automatic t_oper();
      cmd(CMD_OPER_PTR_WRITE, 16'h0000);
      cmd(CMD_OPER_NTR_WRITE, 16'h0002);
      cmd(CMD_OPER_ENAB_WRITE, 16'h0002);
      cmd(CMD_SRE_WRITE, 16'h0080);
      alarm = 4'h2;
      idle(6);
      q(CMD_OPER_EVENT_QUERY, 16'h0000);
      alarm = 4'h0;
      idle(6);
      chk_bit(STATUS_BYTE[7], 1'b1);
      chk_bit(SERVICE_REQ, 1'b1);
      q(CMD_OPER_EVENT_QUERY, 16'h0002);
   endtask
   task automatic t_queue();
      queue = 1'b1;
      idle(3);
      chk_bit(STATUS_BYTE[4], 1'b1);
      queue = 1'b0;
      idle(3);
      chk_bit(STATUS_BYTE[4], 1'b0);
   endtask
   // exception type field and remote level through their rising filters
   task automatic t_inputs();
      cmd(CMD_QUES_PTR_WRITE, 16'h00ff);
      cmd(CMD_OPER_PTR_WRITE, 16'h0010);
      exc = 8'h05;
      remote = 1'b1;
      idle(6);
      q(CMD_QUES_EVENT_QUERY, 16'h0005);
      q(CMD_OPER_EVENT_QUERY, 16'h0010);
      exc = 8'h00;
      remote = 1'b0;
      idle(6);
   endtask
   // second reset in mid-run: power-on bit back, enables and outputs cleared
   task automatic t_rerun();
      cmd(CMD_ESE_WRITE, 16'h0024);
      RST = 1'b1;
      idle(2);
      RST = 1'b0;
      q(CMD_ESR_QUERY, 16'h0080);
      chk_word({8'h00, ESE_MASK}, 16'h0000);
      chk_word({8'h00, STATUS_BYTE}, 16'h0000);
      chk_bit(SERVICE_REQ, 1'b0);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      RST = 1'b1;
      {cmd_err, exec_err, qry_err, cfg_bad, cfg_date, mb_load} = 6'h00;
      {crc, tmo, remote, queue} = 4'h0;
      exc = 8'h00;
      alarm = 4'h0;
      MBERR_CODE = 16'h0000;
      idle(2);
      RST = 1'b0;
      t_reset();
      t_std_events();
      t_modbus();
      t_ques();
      t_oper();
      t_queue();
      t_inputs();
      t_rerun();
      stop_test();
   end
endmodule
